// file: rtl/lvds_cfg_if.sv
/*
 * Configuration bundle from the register file to the serializer core.
 * Assumes all fields live in the system clock domain.
 */
`timescale 1ns/1ps
interface lvds_cfg_if;
  import lvds_tx_pkg::*;

  logic [7:0] setup_hold;
  logic [7:0] output_level;
  logic [7:0] channel_en;

  modport regs
  (
    output setup_hold,
    output output_level,
    output channel_en
  );

  modport core
  (
    input setup_hold,
    input output_level,
    input channel_en
  );
endinterface

// file: rtl/lvds_pixel_transmitter.sv
/*
 * Dual pixel serializer core: captures 70 parallel bits per pixel clock
 * and emits them as ten 7-slot lane frames plus a clock lane frame,
 * for a 7x analog serializer downstream.
 * Assumes pixel_clock_in is unrelated to clock; analog level and delay
 * fields drive the pad ring directly.
 */
`timescale 1ns/1ps
module lvds_pixel_transmitter
  import lvds_tx_pkg::*;
#(
  parameter int RELOCK_LEN = RELOCK_CYCLES
)
(
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                pixel_clock_in,
  input  wire logic                edge_select_pin,
  input  wire logic                dual_pixel_mode,
  input  wire logic                power_down_n,
  input  wire logic [RGB_W-1:0]    odd_rgb,
  input  wire logic [RGB_W-1:0]    even_rgb,
  input  wire logic                hsync,
  input  wire logic                vsync,
  input  wire logic                data_enable,
  input  wire logic [1:0]          user_ctl,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  output logic [WORD_W-1:0]        lane_frame,
  output logic [SLOTS-1:0]         clock_lane_frame,
  output logic [SETUP_HOLD_W-1:0]  sample_delay_code,
  output logic                     even_swing_reduced,
  output logic                     odd_swing_reduced,
  output logic [1:0]               even_offset_code,
  output logic [1:0]               odd_offset_code,
  output logic                     link_active
);

  lvds_cfg_if cfg_bus ();

  logic [1:0]           pd_sync_ff;
  logic [RELOCK_W-1:0]  relock_cnt_ff;
  logic                 tx_on_ff;
  logic [CHAN_EN_W-1:0] en_hold_ff;
  logic                 en_req_ff;
  logic [1:0]           en_ack_sync_ff;
  logic                 en_pending;
  logic [1:0]           pix_rst_ff;
  logic                 pix_rst_n;
  logic [1:0]           pix_req_sync_ff;
  logic                 pix_req_prev_ff;
  logic [CHAN_EN_W-1:0] pix_en_ff;
  logic [1:0]           edge_sync_ff;
  logic [1:0]           dual_sync_ff;
  logic [1:0]           on_sync_ff;
  logic [WORD_W-1:0]    cap_rise_ff;
  logic [WORD_W-1:0]    cap_fall_ff;
  logic [WORD_W-1:0]    in_word;
  logic [WORD_W-1:0]    sel_word;
  logic [WORD_W-1:0]    nxt_lane_frame;
  logic [WORD_W-1:0]    lane_frame_ff;
  logic [SLOTS-1:0]     clock_lane_ff;
  logic                 odd_lanes_on;
  logic                 even_lanes_on;

  serial_config_port u_config
  (
    .clock   (clock),
    .reset_n (reset_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .cfg     (cfg_bus.regs)
  );

  ////////////////////////////////////////////////////////////////////
  // analog control fields, static levels for the pad ring
  // swing, offset and delay select
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      even_swing_reduced <= 1'b0;
      odd_swing_reduced  <= 1'b0;
      even_offset_code   <= 2'h0;
      odd_offset_code    <= 2'h0;
      sample_delay_code  <= 3'h0;
    end
    else
    begin
      even_swing_reduced <= cfg_bus.output_level[EVEN_SWING_BIT];
      odd_swing_reduced  <= cfg_bus.output_level[ODD_SWING_BIT];
      even_offset_code   <= cfg_bus.output_level[EVEN_OFFSET_LSB +: 2];
      odd_offset_code    <= cfg_bus.output_level[ODD_OFFSET_LSB +: 2];
      sample_delay_code  <= cfg_bus.setup_hold[SETUP_HOLD_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // power down and relock wait in the system domain
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      pd_sync_ff <= 2'h0;
    else
      pd_sync_ff <= {pd_sync_ff[0], power_down_n};
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      relock_cnt_ff <= '0;
      tx_on_ff      <= 1'b0;
    end
    else if (!pd_sync_ff[1])
    begin
      relock_cnt_ff <= '0;
      tx_on_ff      <= 1'b0;
    end
    else if (relock_cnt_ff == RELOCK_W'(RELOCK_LEN - 1))
      tx_on_ff <= 1'b1;
    else
      relock_cnt_ff <= relock_cnt_ff + 1'b1;
  end

  assign link_active = tx_on_ff;

  ////////////////////////////////////////////////////////////////////
  // channel enables cross by toggle handshake
  assign en_pending = en_req_ff != en_ack_sync_ff[1];

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      en_hold_ff     <= CHANNEL_EN_RESET[CHAN_EN_W-1:0];
      en_req_ff      <= 1'b0;
      en_ack_sync_ff <= 2'h0;
    end
    else
    begin
      en_ack_sync_ff <= {en_ack_sync_ff[0], pix_req_sync_ff[1]};
      if (!en_pending && en_hold_ff != cfg_bus.channel_en[CHAN_EN_W-1:0])
      begin
        en_hold_ff <= cfg_bus.channel_en[CHAN_EN_W-1:0];
        en_req_ff  <= ~en_req_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pixel domain reset and synchronisers
  always_ff @(posedge pixel_clock_in or negedge reset_n)
  begin
    if (!reset_n)
      pix_rst_ff <= 2'h0;
    else
      pix_rst_ff <= {pix_rst_ff[0], 1'b1};
  end

  assign pix_rst_n = pix_rst_ff[1];

  always_ff @(posedge pixel_clock_in or negedge pix_rst_n)
  begin
    if (!pix_rst_n)
    begin
      pix_req_sync_ff <= 2'h0;
      pix_req_prev_ff <= 1'b0;
      pix_en_ff       <= CHANNEL_EN_RESET[CHAN_EN_W-1:0];
      edge_sync_ff    <= 2'h0;
      dual_sync_ff    <= 2'h0;
      on_sync_ff      <= 2'h0;
    end
    else
    begin
      pix_req_sync_ff <= {pix_req_sync_ff[0], en_req_ff};
      pix_req_prev_ff <= pix_req_sync_ff[1];
      if (pix_req_sync_ff[1] != pix_req_prev_ff)
        pix_en_ff <= en_hold_ff;
      edge_sync_ff <= {edge_sync_ff[0], edge_select_pin};
      dual_sync_ff <= {dual_sync_ff[0], dual_pixel_mode};
      on_sync_ff   <= {on_sync_ff[0], tx_on_ff};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // input capture on both edges
  // pixels and controls
  assign in_word = {user_ctl, data_enable, vsync, hsync,
                    pix_en_ff[EVEN_IN_EN_BIT] ? even_rgb : {RGB_W{1'b0}},
                    user_ctl, data_enable, vsync, hsync,
                    pix_en_ff[ODD_IN_EN_BIT] ? odd_rgb : {RGB_W{1'b0}}};

  always_ff @(posedge pixel_clock_in or negedge pix_rst_n)
  begin
    if (!pix_rst_n)
      cap_rise_ff <= '0;
    else
      cap_rise_ff <= in_word;
  end

  always_ff @(negedge pixel_clock_in or negedge pix_rst_n)
  begin
    if (!pix_rst_n)
      cap_fall_ff <= '0;
    else
      cap_fall_ff <= in_word;
  end

  assign sel_word = edge_sync_ff[1] ? cap_fall_ff : cap_rise_ff;

  ////////////////////////////////////////////////////////////////////
  // lane frames
  // group gating
  assign odd_lanes_on  = on_sync_ff[1] & pix_en_ff[ODD_OUT_EN_BIT];
  assign even_lanes_on = on_sync_ff[1] & pix_en_ff[EVEN_OUT_EN_BIT] & dual_sync_ff[1];

  generate
    for (genvar lane = 0; lane < LANES; lane++)
    begin : g_lane
      logic [SLOTS-1:0] bits;
      logic             lane_on;
      assign bits    = sel_word[lane*SLOTS +: SLOTS];
      assign lane_on = (lane < LANES / 2) ? odd_lanes_on : even_lanes_on;
      assign nxt_lane_frame[lane*SLOTS +: SLOTS] = lane_on ?
        {bits[2], bits[3], bits[4], bits[5], bits[6], bits[0], bits[1]} : IDLE_FRAME;
    end
  endgenerate

  always_ff @(posedge pixel_clock_in or negedge pix_rst_n)
  begin
    if (!pix_rst_n)
    begin
      lane_frame_ff <= '0;
      clock_lane_ff <= IDLE_FRAME;
    end
    else
    begin
      lane_frame_ff <= nxt_lane_frame;
      clock_lane_ff <= on_sync_ff[1] ? CLOCK_LANE_PATTERN : IDLE_FRAME;
    end
  end

  assign lane_frame       = lane_frame_ff;
  assign clock_lane_frame = clock_lane_ff;

endmodule // lvds_pixel_transmitter

// file: rtl/lvds_tx_pkg.sv
/*
 * Shared constants for the dual pixel serializer: register map,
 * field positions, reset values, lane layout, timing counts and the
 * states of the two-wire configuration port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lvds_tx_pkg;

  ////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] REG_SETUP_HOLD    = 8'h19;
  localparam logic [7:0] REG_OUTPUT_LEVEL  = 8'h1C;
  localparam logic [7:0] REG_CHANNEL_EN    = 8'h1D;

  localparam logic [7:0] SETUP_HOLD_RESET  = 8'h00;
  localparam logic [7:0] OUTPUT_LEVEL_RESET = 8'h00;
  localparam logic [7:0] CHANNEL_EN_RESET  = 8'h0F;

  // output level fields and delay code width
  localparam int EVEN_SWING_BIT  = 5;
  localparam int ODD_SWING_BIT   = 4;
  localparam int EVEN_OFFSET_LSB = 2;
  localparam int ODD_OFFSET_LSB  = 0;
  localparam int SETUP_HOLD_W    = 3;

  // channel enable fields
  localparam int ODD_IN_EN_BIT   = 0;
  localparam int EVEN_IN_EN_BIT  = 1;
  localparam int ODD_OUT_EN_BIT  = 2;
  localparam int EVEN_OUT_EN_BIT = 3;
  localparam int CHAN_EN_W       = 4;

  // arbitrary neutral bus address
  localparam logic [6:0] DEVICE_ADDR = 7'h2A;

  ////////////////////////////////////////////////////////////////////
  // lane layout
  localparam int RGB_W        = 30;
  localparam int GROUP_W      = 35;
  localparam int LANES        = 10;
  localparam int SLOTS        = 7;
  localparam int WORD_W       = LANES * SLOTS;
  localparam logic [6:0] CLOCK_LANE_PATTERN = 7'h63;
  localparam logic [6:0] IDLE_FRAME         = 7'h00;

  ////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLOCK_MHZ        = 125;
  localparam int RELOCK_TIME_MS   = 10;
  localparam int RELOCK_CYCLES    = RELOCK_TIME_MS * 1000 * CLOCK_MHZ;
  localparam int RELOCK_W         = 21;

  ////////////////////////////////////////////////////////////////////
  // two-wire port states
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_DEV     = 4'b0001,
    ST_DEV_ACK = 4'b0010,
    ST_REG     = 4'b0011,
    ST_REG_ACK = 4'b0100,
    ST_WR      = 4'b0101,
    ST_WR_ACK  = 4'b0110,
    ST_RD      = 4'b0111,
    ST_RD_ACK  = 4'b1000
  } port_state_t;

endpackage

// file: rtl/serial_config_port.sv
/*
 * Two-wire serial slave holding the configuration registers.
 * Assumes scl and sda come from pins asynchronous to clock; sda is
 * open drain and driven low only while sda_oe is high.
 */
`timescale 1ns/1ps
module serial_config_port
  import lvds_tx_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   reset_n,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  output logic        sda_out,
  output logic        sda_oe,
  lvds_cfg_if.regs    cfg
);

  logic [1:0]  scl_sync_ff;
  logic [1:0]  sda_sync_ff;
  logic        scl_prev_ff;
  logic        sda_prev_ff;
  port_state_t state_ff;
  logic [3:0]  bit_cnt_ff;
  logic [7:0]  shift_ff;
  logic [7:0]  rd_shift_ff;
  logic [7:0]  ptr_ff;
  logic        rw_ff;
  logic        nack_ff;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  logic        wr_strobe;
  logic [7:0]  rd_value;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
    end
  end

  assign scl_rise   = scl_sync_ff[1] & ~scl_prev_ff;
  assign scl_fall   = ~scl_sync_ff[1] & scl_prev_ff;
  assign start_seen = scl_sync_ff[1] & scl_prev_ff & sda_prev_ff & ~sda_sync_ff[1];
  assign stop_seen  = scl_sync_ff[1] & scl_prev_ff & ~sda_prev_ff & sda_sync_ff[1];
  assign wr_strobe  = scl_fall && state_ff == ST_WR && bit_cnt_ff == 4'h8;

  always_comb
  begin
    case (ptr_ff)
      REG_SETUP_HOLD:   rd_value = cfg.setup_hold;
      REG_OUTPUT_LEVEL: rd_value = cfg.output_level;
      REG_CHANNEL_EN:   rd_value = cfg.channel_en;
      default:          rd_value = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // protocol sequencer
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff    <= ST_IDLE;
      bit_cnt_ff  <= 4'h0;
      shift_ff    <= 8'h00;
      rd_shift_ff <= 8'h00;
      ptr_ff      <= 8'h00;
      rw_ff       <= 1'b0;
      nack_ff     <= 1'b0;
    end
    else if (start_seen)
    begin
      state_ff   <= ST_DEV;
      bit_cnt_ff <= 4'h0;
    end
    else if (stop_seen)
    begin
      state_ff <= ST_IDLE;
    end
    else if (scl_rise)
    begin
      shift_ff   <= {shift_ff[6:0], sda_sync_ff[1]};
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      nack_ff    <= sda_sync_ff[1];
    end
    else if (scl_fall)
    begin
      case (state_ff)
        ST_DEV:
        begin
          if (bit_cnt_ff == 4'h8)
          begin
            state_ff <= (shift_ff[7:1] == DEVICE_ADDR) ? ST_DEV_ACK : ST_IDLE;
            rw_ff    <= shift_ff[0];
          end
        end
        ST_DEV_ACK:
        begin
          bit_cnt_ff  <= 4'h0;
          rd_shift_ff <= rd_value;
          state_ff    <= rw_ff ? ST_RD : ST_REG;
        end
        ST_REG:
        begin
          if (bit_cnt_ff == 4'h8)
          begin
            ptr_ff   <= shift_ff;
            state_ff <= ST_REG_ACK;
          end
        end
        ST_REG_ACK:
        begin
          bit_cnt_ff <= 4'h0;
          state_ff   <= ST_WR;
        end
        ST_WR:
        begin
          if (bit_cnt_ff == 4'h8)
            state_ff <= ST_WR_ACK;
        end
        ST_WR_ACK:
        begin
          ptr_ff     <= ptr_ff + 8'h01;
          bit_cnt_ff <= 4'h0;
          state_ff   <= ST_WR;
        end
        ST_RD:
        begin
          if (bit_cnt_ff == 4'h8)
            state_ff <= ST_RD_ACK;
          else
            rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
        end
        ST_RD_ACK:
        begin
          bit_cnt_ff <= 4'h0;
          if (nack_ff)
            state_ff <= ST_IDLE;
          else
          begin
            ptr_ff      <= ptr_ff + 8'h01;
            rd_shift_ff <= rd_value;
            state_ff    <= ST_RD;
          end
        end
        default: state_ff <= state_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register file, all defaults usable without any write
  // working defaults
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg.setup_hold   <= SETUP_HOLD_RESET;
      cfg.output_level <= OUTPUT_LEVEL_RESET;
      cfg.channel_en   <= CHANNEL_EN_RESET;
    end
    else if (wr_strobe)
    begin
      case (ptr_ff)
        REG_SETUP_HOLD:   cfg.setup_hold   <= {5'h00, shift_ff[SETUP_HOLD_W-1:0]};
        REG_OUTPUT_LEVEL: cfg.output_level <= {2'h0, shift_ff[5:0]};
        REG_CHANNEL_EN:   cfg.channel_en   <= {4'h0, shift_ff[CHAN_EN_W-1:0]};
        default:          cfg.channel_en   <= cfg.channel_en;
      endcase
    end
  end

  assign sda_out = 1'b0;
  // read data moves only after scl falls, never while scl is high
  assign sda_oe  = (state_ff == ST_DEV_ACK) || (state_ff == ST_REG_ACK) || (state_ff == ST_WR_ACK)
                   || (state_ff == ST_RD && !rd_shift_ff[7]);

endmodule // serial_config_port

// file: tb/lvds_pixel_transmitter_assertions.sv
/* Concurrent checks on the serializer top ports.
   Assumes the bind below hands on RELOCK_LEN. */
`timescale 1ns/1ps
module lvds_pixel_transmitter_assertions
  import lvds_tx_pkg::*;
#(
  parameter int RELOCK_LEN = 16
)
(
  input wire logic                    clock,
  input wire logic                    reset_n,
  input wire logic                    pixel_clock_in,
  input wire logic                    dual_pixel_mode,
  input wire logic                    power_down_n,
  input wire logic                    scl_in,
  input wire logic                    sda_oe,
  input wire logic [WORD_W-1:0]       lane_frame,
  input wire logic [SLOTS-1:0]        clock_lane_frame,
  input wire logic [SETUP_HOLD_W-1:0] sample_delay_code,
  input wire logic                    even_swing_reduced,
  input wire logic                    odd_swing_reduced,
  input wire logic [1:0]              even_offset_code,
  input wire logic [1:0]              odd_offset_code,
  input wire logic                    link_active
);
  int unsigned up_cnt_ff;

  // clocks since power-up, saturating
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      up_cnt_ff <= 32'h0;
    else if (!power_down_n)
      up_cnt_ff <= 32'h0;
    else if (up_cnt_ff < 32'hFFFF)
      up_cnt_ff <= up_cnt_ff + 32'h1;

  ////////////////////////////////////////
  sequence s_link_down;
    (!link_active) [*4];
  endsequence
  sequence s_single_held;
    (!dual_pixel_mode) [*6];
  endsequence

  a_idle_when_down: assert property (
    @(posedge pixel_clock_in) disable iff (!reset_n) s_link_down |=> lane_frame == '0 && clock_lane_frame == IDLE_FRAME)
    else $error("frames not idle while link down");
  a_clock_lane_shape: assert property (
    @(posedge pixel_clock_in) disable iff (!reset_n)
    (clock_lane_frame != IDLE_FRAME || lane_frame != '0) |-> clock_lane_frame == CLOCK_LANE_PATTERN)
    else $error("clock lane pattern wrong");
  a_single_even_quiet: assert property (
    @(posedge pixel_clock_in) disable iff (!reset_n) s_single_held |=> lane_frame[WORD_W-1:GROUP_W] == '0)
    else $error("even lanes busy in single mode");
  a_relock_hold: assert property (
    @(posedge clock) disable iff (!reset_n) $rose(power_down_n) |-> (!link_active) [*8])
    else $error("link active before relock");
  a_relock_prompt: assert property (
    @(posedge clock) disable iff (!reset_n) $fell(power_down_n) |-> ##[1:5] !link_active)
    else $error("link stays active in power down");
  a_relock_count: assert property (
    @(posedge clock) disable iff (!reset_n)
    $rose(link_active) |-> up_cnt_ff + 1 >= RELOCK_LEN && up_cnt_ff <= RELOCK_LEN + 5)
    else $error("relock time wrong");
  a_levels_on_write: assert property (
    @(posedge clock) disable iff (!reset_n)
    $changed({even_swing_reduced, odd_swing_reduced, even_offset_code, odd_offset_code}) |-> !scl_in)
    else $error("level fields moved outside a write");
  a_delay_on_write: assert property (
    @(posedge clock) disable iff (!reset_n) $changed(sample_delay_code) |-> !scl_in)
    else $error("delay code moved outside a write");
  a_sda_scl_low: assert property (
    @(posedge clock) disable iff (!reset_n) $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("sda driven change while scl high");
endmodule // lvds_pixel_transmitter_assertions

bind lvds_pixel_transmitter lvds_pixel_transmitter_assertions #(.RELOCK_LEN(RELOCK_LEN)) i_chk (
  .clock(clock), .reset_n(reset_n), .pixel_clock_in(pixel_clock_in), .dual_pixel_mode(dual_pixel_mode),
  .power_down_n(power_down_n), .scl_in(scl_in), .sda_oe(sda_oe), .lane_frame(lane_frame),
  .clock_lane_frame(clock_lane_frame), .sample_delay_code(sample_delay_code),
  .even_swing_reduced(even_swing_reduced), .odd_swing_reduced(odd_swing_reduced),
  .even_offset_code(even_offset_code), .odd_offset_code(odd_offset_code), .link_active(link_active));

// file: tb/pixel_clock_source.sv
/* Video source model: the free-running pixel clock.
   Assumes the bench drives pixel data away from its edges. */
`timescale 1ns/1ps
module pixel_clock_source
#(
  parameter real HALF_NS = 6.0
)
(
  output logic pixel_clock_in
);
  initial
  begin
    pixel_clock_in = 1'b0;
    #3;
    forever #(HALF_NS) pixel_clock_in = ~pixel_clock_in;
  end
endmodule // pixel_clock_source

// file: tb/tb_dual_pixel_lvds_serializer.sv
/* Self-checking bench for the dual pixel serializer.
   Assumes the package, the design, its checker and the clock source. */
`timescale 1ns/1ps
`define CHECK(nm, ex, got) \
  begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module tb_dual_pixel_lvds_serializer;
  import lvds_tx_pkg::*;
  localparam int RELOCK_SIM = 16;
  localparam int QTR        = 10;
  logic                    clock, reset_n, pixel_clock_in, edge_select_pin, dual_pixel_mode, power_down_n;
  logic [RGB_W-1:0]        odd_rgb, even_rgb;
  logic [4:0]              ctl;
  logic                    scl_in, sda_m, sda_line, sda_out, sda_oe, link_active, ack;
  logic [WORD_W-1:0]       lane_frame;
  logic [SLOTS-1:0]        clock_lane_frame;
  logic [SETUP_HOLD_W-1:0] sample_delay_code;
  logic                    even_swing_reduced, odd_swing_reduced;
  logic [1:0]              even_offset_code, odd_offset_code;
  logic [31:0]             rng;
  logic [7:0]              rd, lvl;
  logic [3:0]              en_tab [5] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF};
  int                      fail_count, total_checks;

  // open-drain line with pull-up
  assign sda_line = sda_m & (sda_oe ? sda_out : 1'b1);

  pixel_clock_source i_src (.pixel_clock_in(pixel_clock_in));
  lvds_pixel_transmitter #(.RELOCK_LEN(RELOCK_SIM)) i_dut (
    .clock(clock), .reset_n(reset_n), .pixel_clock_in(pixel_clock_in), .edge_select_pin(edge_select_pin),
    .dual_pixel_mode(dual_pixel_mode), .power_down_n(power_down_n), .odd_rgb(odd_rgb), .even_rgb(even_rgb),
    .hsync(ctl[0]), .vsync(ctl[1]), .data_enable(ctl[2]), .user_ctl(ctl[4:3]), .scl_in(scl_in),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .lane_frame(lane_frame),
    .clock_lane_frame(clock_lane_frame), .sample_delay_code(sample_delay_code),
    .even_swing_reduced(even_swing_reduced), .odd_swing_reduced(odd_swing_reduced),
    .even_offset_code(even_offset_code), .odd_offset_code(odd_offset_code), .link_active(link_active));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////
  function automatic logic [31:0] next_rand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic logic [WORD_W-1:0] model_frame(input logic [3:0] en, input logic dual);
    logic [GROUP_W-1:0] w;
    logic [6:0]         b;
    logic [WORD_W-1:0]  f;
    f = '0;
    for (int g = 0; g < 2; g++)
    begin
      w = {ctl, en[g] ? (g == 0 ? odd_rgb : even_rgb) : 30'h0};
      for (int k = 0; k < 5; k++)
      begin
        b = w[7*k +: 7];
        if (en[g+2] && (g == 0 || dual))
          f[GROUP_W*g + 7*k +: 7] = {b[2], b[3], b[4], b[5], b[6], b[0], b[1]};
      end
    end
    return f;
  endfunction

  task automatic tw_wait();
    repeat (QTR) @(negedge clock);
  endtask

  task automatic tw_bit(input logic b, output logic r);
    sda_m = b;
    tw_wait();
    scl_in = 1'b1;
    tw_wait();
    r = sda_line;
    scl_in = 1'b0;
    tw_wait();
  endtask

  // start is (1,0), stop is (0,1)
  task automatic tw_cond(input logic first, input logic last);
    sda_m = first;
    tw_wait();
    scl_in = 1'b1;
    tw_wait();
    sda_m = last;
    tw_wait();
    scl_in = last;
  endtask

  task automatic tw_byte(input logic [7:0] d, output logic [7:0] q, output logic k);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      tw_bit(d[i], r);
      q = {q[6:0], r};
    end
    tw_bit(1'b1, r);
    k = ~r;
  endtask

  task automatic reg_op(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic       k;
    logic [7:0] j;
    tw_cond(1'b1, 1'b0);
    tw_byte({DEVICE_ADDR, 1'b0}, j, k);
    tw_byte(a, j, k);
    if (wr)
      tw_byte(d, j, k);
    else
    begin
      tw_cond(1'b1, 1'b0);
      tw_byte({DEVICE_ADDR, 1'b1}, j, k);
      tw_byte(8'hFF, q, j[0]);
    end
    `CHECK("register ack", 1'b1, k)
    tw_cond(1'b0, 1'b1);
  endtask

  task automatic check_pixels(input logic [3:0] en);
    @(negedge clock);
    odd_rgb = RGB_W'(next_rand());
    even_rgb = RGB_W'(next_rand());
    ctl = 5'(next_rand());
    repeat (12) @(posedge pixel_clock_in);
    @(negedge clock);
    `CHECK("lane frame", model_frame(en, dual_pixel_mode), lane_frame)
    `CHECK("clock lane", CLOCK_LANE_PATTERN, clock_lane_frame)
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////
  initial
  begin
    repeat (80000) @(posedge clock);
    fail_count++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_of_test();
  end

  initial
  begin
    rng = 32'hD468;
    fail_count = 0;
    total_checks = 0;
    {reset_n, edge_select_pin, dual_pixel_mode, power_down_n, scl_in, sda_m} = 6'h07;
    {odd_rgb, even_rgb, ctl} = '0;
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    `CHECK("link at start", 1'b0, link_active)
    reg_op(1'b0, REG_SETUP_HOLD, 8'h00, rd);
    `CHECK("delay reset", SETUP_HOLD_RESET, rd)
    reg_op(1'b0, REG_OUTPUT_LEVEL, 8'h00, rd);
    `CHECK("level reset", OUTPUT_LEVEL_RESET, rd)
    reg_op(1'b0, REG_CHANNEL_EN, 8'h00, rd);
    `CHECK("enable reset", CHANNEL_EN_RESET, rd)
    `CHECK("default fields", 9'h000, {sample_delay_code, even_swing_reduced, odd_swing_reduced, even_offset_code, odd_offset_code})
    check_pixels(4'hF);
    $display("test defaults done");
    for (int c = 0; c < 8; c++)
    begin
      reg_op(1'b1, REG_SETUP_HOLD, 8'(c), rd);
      `CHECK("sample delay", 3'(c), sample_delay_code)
    end
    reg_op(1'b0, REG_SETUP_HOLD, 8'h00, rd);
    `CHECK("delay readback", 8'h07, rd)
    repeat (4)
    begin
      lvl = 8'(next_rand()) & 8'h3F;
      reg_op(1'b1, REG_OUTPUT_LEVEL, lvl, rd);
      `CHECK("swing bits", lvl[5:4], {even_swing_reduced, odd_swing_reduced})
      `CHECK("offset codes", lvl[3:0], {even_offset_code, odd_offset_code})
      reg_op(1'b0, REG_OUTPUT_LEVEL, 8'h00, rd);
      `CHECK("level readback", lvl, rd)
    end
    reg_op(1'b1, 8'h30, 8'hFF, rd);
    reg_op(1'b0, 8'h30, 8'h00, rd);
    `CHECK("unmapped read", 8'h00, rd)
    tw_cond(1'b1, 1'b0);
    tw_byte({DEVICE_ADDR ^ 7'h01, 1'b0}, rd, ack);
    tw_cond(1'b0, 1'b1);
    `CHECK("foreign address ack", 1'b0, ack)
    $display("test registers done");
    for (int m = 0; m < 4; m++)
    begin
      {dual_pixel_mode, edge_select_pin} = 2'(m);
      check_pixels(4'hF);
    end
    foreach (en_tab[i])
    begin
      reg_op(1'b1, REG_CHANNEL_EN, {4'h0, en_tab[i]}, rd);
      check_pixels(en_tab[i]);
    end
    $display("test pixel modes done");
    power_down_n = 1'b0;
    repeat (12) @(posedge pixel_clock_in);
    @(negedge clock);
    `CHECK("powered down", 78'h0, {link_active, clock_lane_frame, lane_frame})
    power_down_n = 1'b1;
    repeat (8) @(negedge clock);
    `CHECK("relocking", 1'b0, link_active)
    for (int i = 0; i < 100 && link_active !== 1'b1; i++)
      @(negedge clock);
    check_pixels(4'hF);
    $display("test power down done");
    end_of_test();
  end
endmodule // tb_dual_pixel_lvds_serializer
